//--- autoreload_timer_capture.sv
// Autoreload 12-bit upcounter with capture, compare flags and bus slave.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Capture flag sets; capture read clears it.
// [RULE_02] Capture interrupt only when its enable set.
// [RULE_03] Clock select: 01 aux, 10 cpu, else stop.
// [RULE_04] Overflow flag on wrap; status read clears.
// [RULE_05] Overflow enable gates overflow interrupt.
// [RULE_06] Compare enable masks combined compare request.
// [RULE_07] Counter increments per selected tick.
// [RULE_08] Overflow reloads counter from reload value.
// [RULE_09] Counter readable as high and low, no snapshot.
// [RULE_10] Reload value twelve bits, writable, resets zero.
// [RULE_11] Reload value sets the compare period.
// [RULE_12] Source select routes aux pin; twenty-bit capture.
// [RULE_13] Long capture needs aux clock and pin.
// [RULE_14] Disable one capture interrupt before cascading.
// [RULE_15] Change source with interrupts off, clear flags.
// [RULE_16] Capture value is high over low halves.
// [RULE_17] Compare flag on duty match; channel read clears.
// [RULE_18] Interrupt when any enabled flag set.
module autoreload_timer_capture (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic aux_tick,
	input wire logic main_capture_input,
	input wire logic aux_capture_pin,
	input wire logic [7:0] aux_counter_value,
	output logic [timer_pkg::DUTY_CH-1:0] compare_match,
	output logic irq
);
	logic [timer_pkg::CNT_W-1:0] main_upcounter;
	logic [timer_pkg::CNT_W-1:0] reload_value;
	logic [timer_pkg::CNT_W-1:0] capture_value;
	logic [7:0] aux_capture_reg;
	logic [1:0] counter_clock_select;
	logic capture_flag, capture_irq_enable, overflow_flag;
	logic overflow_irq_enable, compare_irq_enable, capture_source_select;
	logic [timer_pkg::DUTY_CH-1:0] channel_compare_flag;
	logic [timer_pkg::CNT_W-1:0] duty_cycle_value [timer_pkg::DUTY_CH];
	logic [timer_pkg::EV_W-1:0] irq_status, irq_mask;
	logic cap_in_prev, tick, wrap, cap_evt, ack_reg;
	logic rd_acc, wr_acc;
	logic [timer_pkg::EV_W-1:0] ev;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	// One access cycle of wait, then the answer is given.
	assign waitrequest = (read | write) & ~ack_reg;
	assign rd_acc = read & ack_reg;
	assign wr_acc = write & ack_reg;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read | write) & ~ack_reg;
		end
	end

	always_comb begin
		unique case (counter_clock_select)
			timer_pkg::CLK_AUX: tick = aux_tick; // RULE_03
			timer_pkg::CLK_CPU: tick = 1'b1; // RULE_03
			default: tick = 1'b0; // RULE_03
		endcase
	end
	assign wrap = tick && main_upcounter == timer_pkg::CNT_MAX;
	wire logic cap_src;
	assign cap_src = capture_source_select ? aux_capture_pin : // RULE_12
		main_capture_input;
	assign cap_evt = cap_src & ~cap_in_prev;

	// Counter: counts each tick, restarts from the reload value on wrap.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			main_upcounter <= timer_pkg::CNT_RST;
		end else if (wrap) begin
			main_upcounter <= reload_value; // RULE_08 RULE_11
		end else if (tick) begin
			main_upcounter <= main_upcounter + 12'h001; // RULE_07
		end
	end

	// Capture edge detector and registers.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_in_prev <= 1'b0;
			capture_value <= timer_pkg::CNT_RST;
			aux_capture_reg <= timer_pkg::BYTE_RST;
		end else begin
			cap_in_prev <= cap_src;
			if (cap_evt) begin
				capture_value <= main_upcounter;
				aux_capture_reg <= aux_counter_value; // RULE_12
			end
		end
	end

	// Control bits written by software.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_irq_enable <= 1'b0;
			counter_clock_select <= timer_pkg::CLK_OFF0; // RULE_03
			overflow_irq_enable <= 1'b0; // RULE_05
			compare_irq_enable <= 1'b0; // RULE_06
			capture_source_select <= 1'b0;
			reload_value <= timer_pkg::CNT_RST; // RULE_10
			irq_mask <= '0;
		end else if (wr_acc) begin
			if (hit(address, timer_pkg::ADDR_CTRL_STATUS)) begin
				capture_irq_enable <= writedata[timer_pkg::BIT_CAPTURE_IRQ_EN];
				counter_clock_select <= writedata[timer_pkg::BIT_CLK_SEL_HI:
					timer_pkg::BIT_CLK_SEL_LO];
				overflow_irq_enable <= writedata[timer_pkg::BIT_OVERFLOW_IRQ_EN];
				compare_irq_enable <= writedata[timer_pkg::BIT_COMPARE_IRQ_EN];
			end
			if (hit(address, timer_pkg::ADDR_AUTORELOAD1_HIGH)) begin
				reload_value[11:8] <= writedata[3:0]; // RULE_10
			end
			if (hit(address, timer_pkg::ADDR_AUTORELOAD1_LOW)) begin
				reload_value[7:0] <= writedata[7:0]; // RULE_10
			end
			if (hit(address, timer_pkg::ADDR_CTRL2)) begin
				capture_source_select <=
					writedata[timer_pkg::BIT_CAPTURE_SOURCE]; // RULE_12
			end
			if (hit(address, timer_pkg::ADDR_IRQ_MASK)) begin
				irq_mask <= writedata[timer_pkg::EV_W-1:0];
			end
		end
	end

	// Duty values, one per channel.
	genvar g;
	generate
		for (g = 0; g < timer_pkg::DUTY_CH; g++) begin : gen_ch
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					duty_cycle_value[g] <= timer_pkg::CNT_RST;
				end else if (wr_acc && hit(address,
					timer_pkg::ADDR_DUTY0 + 4'(g))) begin
					duty_cycle_value[g] <= writedata[11:0];
				end
			end
			assign compare_match[g] = channel_compare_flag[g];
			// Set wins over the read clear.
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					channel_compare_flag[g] <= 1'b0;
				end else if (main_upcounter == duty_cycle_value[g]) begin
					channel_compare_flag[g] <= 1'b1; // RULE_17
				end else if (rd_acc && hit(address,
					timer_pkg::ADDR_CH_STATUS)) begin
					channel_compare_flag[g] <= 1'b0; // RULE_17
				end
			end
		end
	endgenerate

	// Hardware flags; a set in the clearing cycle wins.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_flag <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			if (cap_evt) begin
				capture_flag <= 1'b1; // RULE_01
			end else if (rd_acc && (hit(address, timer_pkg::ADDR_CAPTURE_HIGH)
				|| hit(address, timer_pkg::ADDR_CAPTURE_LOW))) begin
				capture_flag <= 1'b0; // RULE_01
			end
			if (wrap) begin
				overflow_flag <= 1'b1; // RULE_04
			end else if (rd_acc && hit(address,
				timer_pkg::ADDR_CTRL_STATUS)) begin
				overflow_flag <= 1'b0; // RULE_04
			end
		end
	end

	// Sticky event status, write one to clear, masked onto irq.
	assign ev[timer_pkg::EV_CAPTURE] = capture_flag &
		capture_irq_enable; // RULE_02
	assign ev[timer_pkg::EV_OVERFLOW] = overflow_flag &
		overflow_irq_enable; // RULE_05
	assign ev[timer_pkg::EV_COMPARE] = (|channel_compare_flag) &
		compare_irq_enable; // RULE_06
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= '0;
		end else if (wr_acc && hit(address, timer_pkg::ADDR_IRQ_STATUS)) begin
			irq_status <= (irq_status & ~writedata[timer_pkg::EV_W-1:0]) | ev;
		end else begin
			irq_status <= irq_status | ev;
		end
	end
	assign irq = |(irq_status & irq_mask); // RULE_18

	// Read data is registered in the wait cycle, before the answer is given.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= 32'h0000_0000;
		end else if (read & ~ack_reg) begin
			readdata <= 32'h0000_0000;
			unique case (address)
				timer_pkg::ADDR_CTRL_STATUS: readdata[6:0] <= {capture_flag,
					capture_irq_enable, counter_clock_select, overflow_flag,
					overflow_irq_enable, compare_irq_enable};
				timer_pkg::ADDR_COUNTER1_HIGH:
					readdata[3:0] <= main_upcounter[11:8]; // RULE_09
				timer_pkg::ADDR_COUNTER1_LOW:
					readdata[7:0] <= main_upcounter[7:0]; // RULE_09
				timer_pkg::ADDR_AUTORELOAD1_HIGH: readdata[3:0] <= reload_value[11:8];
				timer_pkg::ADDR_AUTORELOAD1_LOW: readdata[7:0] <= reload_value[7:0];
				timer_pkg::ADDR_CAPTURE_HIGH:
					readdata[3:0] <= capture_value[11:8]; // RULE_16
				timer_pkg::ADDR_CAPTURE_LOW:
					readdata[7:0] <= capture_value[7:0]; // RULE_16
				timer_pkg::ADDR_CTRL2:
					readdata[timer_pkg::BIT_CAPTURE_SOURCE] <= capture_source_select;
				timer_pkg::ADDR_AUX_CAPTURE: readdata[7:0] <= aux_capture_reg;
				timer_pkg::ADDR_CH_STATUS:
					readdata[timer_pkg::DUTY_CH-1:0] <= channel_compare_flag;
				timer_pkg::ADDR_IRQ_STATUS:
					readdata[timer_pkg::EV_W-1:0] <= irq_status;
				timer_pkg::ADDR_IRQ_MASK: readdata[timer_pkg::EV_W-1:0] <= irq_mask;
				default: readdata[11:0] <= duty_cycle_value[2'(address - 4'h9)];
			endcase
		end
	end

	// Capture flag and capture registers.
	a_capture_sets: assert property ( // RULE_01
		@(posedge sys_clk) disable iff (!reset_n)
		cap_evt |=> capture_flag)
		else $error("capture flag not set");
	a_capture_clear: assert property ( // RULE_01
		@(posedge sys_clk) disable iff (!reset_n)
		rd_acc && address == timer_pkg::ADDR_CAPTURE_LOW && !cap_evt
		|=> !capture_flag) else $error("capture flag not cleared");
	a_capture_hold: assert property ( // RULE_01
		@(posedge sys_clk) disable iff (!reset_n)
		capture_flag && !(rd_acc && (address == timer_pkg::ADDR_CAPTURE_HIGH
		|| address == timer_pkg::ADDR_CAPTURE_LOW)) |=> capture_flag)
		else $error("capture flag lost");
	a_capture_irq_gate: assert property ( // RULE_02
		@(posedge sys_clk) disable iff (!reset_n)
		!capture_irq_enable |-> !ev[timer_pkg::EV_CAPTURE])
		else $error("capture irq not gated");
	a_capture_pend: assert property ( // RULE_02
		@(posedge sys_clk) disable iff (!reset_n)
		ev[timer_pkg::EV_CAPTURE] |=> irq_status[timer_pkg::EV_CAPTURE])
		else $error("capture irq not pending");
	a_capture_value: assert property ( // RULE_16
		@(posedge sys_clk) disable iff (!reset_n)
		cap_evt |=> capture_value == $past(main_upcounter))
		else $error("capture value wrong");
	a_aux_latch: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (!reset_n)
		cap_evt |=> aux_capture_reg == $past(aux_counter_value))
		else $error("aux capture value wrong");
	a_source_main: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (!reset_n)
		!capture_source_select && main_capture_input && !cap_in_prev
		|-> cap_evt) else $error("main capture edge missed");
	a_source_aux: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (!reset_n)
		capture_source_select && aux_capture_pin && !cap_in_prev
		|-> cap_evt) else $error("aux capture edge missed");
	a_source_block: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (!reset_n)
		capture_source_select && !aux_capture_pin |-> !cap_evt)
		else $error("main pin captured while aux selected");

	// Counter clocking, overflow and reload.
	a_clock_stop: assert property ( // RULE_03
		@(posedge sys_clk) disable iff (!reset_n)
		counter_clock_select inside {2'b00, 2'b11} |=>
		$stable(main_upcounter)) else $error("counter ran while off");
	a_ctrl_write: assert property ( // RULE_03
		@(posedge sys_clk) disable iff (!reset_n)
		wr_acc && address == timer_pkg::ADDR_CTRL_STATUS |=>
		counter_clock_select == $past(writedata[4:3]))
		else $error("clock select not written");
	a_aux_idle: assert property ( // RULE_03
		@(posedge sys_clk) disable iff (!reset_n)
		counter_clock_select == timer_pkg::CLK_AUX && !aux_tick
		|=> $stable(main_upcounter)) else $error("counter ran without tick");
	a_cpu_count: assert property ( // RULE_07
		@(posedge sys_clk) disable iff (!reset_n)
		counter_clock_select == 2'b10 && main_upcounter != 12'hfff |=>
		main_upcounter == $past(main_upcounter) + 12'h001)
		else $error("counter missed cpu tick");
	a_aux_count: assert property ( // RULE_07
		@(posedge sys_clk) disable iff (!reset_n)
		counter_clock_select == timer_pkg::CLK_AUX && aux_tick &&
		main_upcounter != timer_pkg::CNT_MAX |=>
		main_upcounter == $past(main_upcounter) + 12'h001)
		else $error("counter missed aux tick");
	a_reload_wrap: assert property ( // RULE_08
		@(posedge sys_clk) disable iff (!reset_n)
		wrap |=> main_upcounter == $past(reload_value) && overflow_flag)
		else $error("reload or overflow wrong");
	a_overflow_clear: assert property ( // RULE_04
		@(posedge sys_clk) disable iff (!reset_n)
		rd_acc && address == timer_pkg::ADDR_CTRL_STATUS && !wrap
		|=> !overflow_flag) else $error("overflow flag not cleared");
	a_overflow_hold: assert property ( // RULE_04
		@(posedge sys_clk) disable iff (!reset_n)
		overflow_flag && !(rd_acc && address == timer_pkg::ADDR_CTRL_STATUS)
		|=> overflow_flag) else $error("overflow flag lost");
	a_overflow_quiet: assert property ( // RULE_04
		@(posedge sys_clk) disable iff (!reset_n)
		!overflow_flag && !wrap |=> !overflow_flag)
		else $error("overflow flag set without wrap");
	a_overflow_gate: assert property ( // RULE_05
		@(posedge sys_clk) disable iff (!reset_n)
		overflow_flag && overflow_irq_enable |=>
		irq_status[timer_pkg::EV_OVERFLOW]) else $error("overflow lost");
	a_ovf_en_write: assert property ( // RULE_05
		@(posedge sys_clk) disable iff (!reset_n)
		wr_acc && address == timer_pkg::ADDR_CTRL_STATUS |=>
		overflow_irq_enable == $past(writedata[1]))
		else $error("overflow enable not written");
	a_reload_high: assert property ( // RULE_10
		@(posedge sys_clk) disable iff (!reset_n)
		wr_acc && address == timer_pkg::ADDR_AUTORELOAD1_HIGH |=>
		reload_value[11:8] == $past(writedata[3:0]))
		else $error("reload high not written");
	a_reload_low: assert property ( // RULE_10
		@(posedge sys_clk) disable iff (!reset_n)
		wr_acc && address == timer_pkg::ADDR_AUTORELOAD1_LOW |=>
		reload_value[7:0] == $past(writedata[7:0]))
		else $error("reload low not written");

	// Compare flags and interrupt status.
	a_compare_gate: assert property ( // RULE_06
		@(posedge sys_clk) disable iff (!reset_n)
		!compare_irq_enable |-> !ev[timer_pkg::EV_COMPARE])
		else $error("compare not masked");
	a_compare_pend: assert property ( // RULE_06
		@(posedge sys_clk) disable iff (!reset_n)
		ev[timer_pkg::EV_COMPARE] |=> irq_status[timer_pkg::EV_COMPARE])
		else $error("compare irq not pending");
	a_compare_set: assert property ( // RULE_17
		@(posedge sys_clk) disable iff (!reset_n)
		main_upcounter == duty_cycle_value[0] |=> channel_compare_flag[0])
		else $error("compare flag not set");
	a_compare_clear: assert property ( // RULE_17
		@(posedge sys_clk) disable iff (!reset_n)
		rd_acc && address == timer_pkg::ADDR_CH_STATUS &&
		main_upcounter != duty_cycle_value[0] |=> !channel_compare_flag[0])
		else $error("compare flag not cleared");
	a_status_sticky: assert property ( // RULE_18
		@(posedge sys_clk) disable iff (!reset_n)
		irq_status[timer_pkg::EV_CAPTURE] && !(wr_acc &&
		address == timer_pkg::ADDR_IRQ_STATUS && writedata[0])
		|=> irq_status[timer_pkg::EV_CAPTURE]) else $error("status lost");
	a_irq_level: assert property ( // RULE_18
		@(posedge sys_clk) disable iff (!reset_n)
		irq == |(irq_status & irq_mask))
		else $error("irq level wrong");

	// Bus answer: one wait cycle, counter halves read back as they stand.
	a_one_wait: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		ack_reg |=> !ack_reg)
		else $error("acknowledge held too long");
	a_count_high_read: assert property ( // RULE_09
		@(posedge sys_clk) disable iff (!reset_n)
		read && !ack_reg && address == timer_pkg::ADDR_COUNTER1_HIGH |=>
		readdata == {28'h0000000, $past(main_upcounter[11:8])})
		else $error("counter high read wrong");
	a_count_low_read: assert property ( // RULE_09
		@(posedge sys_clk) disable iff (!reset_n)
		read && !ack_reg && address == timer_pkg::ADDR_COUNTER1_LOW |=>
		readdata == {24'h000000, $past(main_upcounter[7:0])})
		else $error("counter low read wrong");
endmodule
`default_nettype wire

//--- timer_pkg.sv
// Package with register map, field layout and reset values of the timer.
package timer_pkg;
	localparam int CNT_W = 12;
	localparam int DUTY_CH = 4;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
	localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Word addresses on the bus.
	localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
	localparam logic [3:0] ADDR_COUNTER1_HIGH = 4'h1;
	localparam logic [3:0] ADDR_COUNTER1_LOW = 4'h2;
	localparam logic [3:0] ADDR_AUTORELOAD1_HIGH = 4'h3;
	localparam logic [3:0] ADDR_AUTORELOAD1_LOW = 4'h4;
	localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h5;
	localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h6;
	localparam logic [3:0] ADDR_CTRL2 = 4'h7;
	localparam logic [3:0] ADDR_AUX_CAPTURE = 4'h8;
	localparam logic [3:0] ADDR_DUTY0 = 4'h9;
	localparam logic [3:0] ADDR_CH_STATUS = 4'hd;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'he;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hf;

	// Control/status bit positions.
	localparam int BIT_CAPTURE_FLAG = 6;
	localparam int BIT_CAPTURE_IRQ_EN = 5;
	localparam int BIT_CLK_SEL_HI = 4;
	localparam int BIT_CLK_SEL_LO = 3;
	localparam int BIT_OVERFLOW_FLAG = 2;
	localparam int BIT_OVERFLOW_IRQ_EN = 1;
	localparam int BIT_COMPARE_IRQ_EN = 0;
	localparam int BIT_CAPTURE_SOURCE = 1;

	// Sticky event bits.
	localparam int EV_CAPTURE = 0;
	localparam int EV_OVERFLOW = 1;
	localparam int EV_COMPARE = 2;
	localparam int EV_W = 3;

	localparam logic [1:0] CLK_OFF0 = 2'b00;
	localparam logic [1:0] CLK_AUX = 2'b01;
	localparam logic [1:0] CLK_CPU = 2'b10;
	localparam logic [1:0] CLK_OFF1 = 2'b11;
endpackage

//--- tb_autoreload_timer_capture.sv
// Self-checking testbench for the autoreload timer with input capture.
`timescale 1ns/1ps
`default_nettype none
module tb_autoreload_timer_capture;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic aux_tick = 1'b0;
	logic main_capture_input = 1'b0;
	logic aux_capture_pin = 1'b0;
	logic [7:0] aux_counter_value = 8'h00;
	logic [3:0] compare_match;
	logic irq;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rnd = 32'h00006eed;
	logic [31:0] lo_q[$];
	logic [31:0] hi_q[$];
	logic [11:0] rel;
	logic [11:0] cv;
	logic [7:0] auxv;

	autoreload_timer_capture DUT (.sys_clk(sys_clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .aux_tick(aux_tick),
		.main_capture_input(main_capture_input),
		.aux_capture_pin(aux_capture_pin),
		.aux_counter_value(aux_counter_value),
		.compare_match(compare_match), .irq(irq));

	always #12.5 sys_clk = ~sys_clk;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task end_sim;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// The hang limit counts as a mismatch.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			end_sim();
		end
	end

	// Read data is taken at the edge where waitrequest is seen low.
	always @(posedge sys_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0 && lo_q.size() > 0) begin
			if (lo_q[0] === hi_q[0])
				check(readdata, lo_q[0]);
			else
				check({31'h0, readdata >= lo_q[0] && readdata <= hi_q[0]}, 32'h1);
			void'(lo_q.pop_front());
			void'(hi_q.pop_front());
		end
	end

	task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		read <= ~w;
		write <= w;
		writedata <= d;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [31:0] lo, input logic [31:0] hi);
		lo_q.push_back(lo);
		hi_q.push_back(hi);
		bus(a, 1'b0, 32'h0);
	endtask

	task rde(input logic [3:0] a, input logic [31:0] v);
		rd(a, v, v);
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task ticks(input int k);
		@(posedge sys_clk);
		aux_tick <= 1'b1;
		repeat (k) @(posedge sys_clk);
		aux_tick <= 1'b0;
	endtask

	task pin(input logic aux);
		@(posedge sys_clk);
		if (aux)
			aux_capture_pin <= 1'b1;
		else
			main_capture_input <= 1'b1;
		repeat (2) @(posedge sys_clk);
		aux_capture_pin <= 1'b0;
		main_capture_input <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 5; a++)
			rde(a[3:0], 32'h0);
		$display("test reset values done");
		rnd = xs(rnd);
		rel = {2'b10, rnd[9:4], 4'h0};
		cv = rel + 12'h003;
		wr(4'h3, {28'h0, rel[11:8]});
		wr(4'h4, {24'h0, rel[7:0]});
		rde(4'h3, {28'h0, rel[11:8]});
		rde(4'h4, {24'h0, rel[7:0]});
		wr(4'hf, 32'h7);
		wr(4'h0, 32'h0a);
		ticks(4099);
		repeat (3) @(posedge sys_clk);
		check({31'h0, irq}, 32'h1);
		rde(4'h1, {28'h0, cv[11:8]});
		rde(4'h2, {24'h0, cv[7:0]});
		rde(4'h0, 32'h0e);
		rde(4'h0, 32'h0a);
		rde(4'he, 32'h2);
		wr(4'hf, 32'h0);
		@(posedge sys_clk);
		check({31'h0, irq}, 32'h0);
		wr(4'he, 32'h2);
		wr(4'hf, 32'h7);
		@(posedge sys_clk);
		check({31'h0, irq}, 32'h0);
		$display("test count and overflow done");
		wr(4'h0, 32'h08);
		pin(1'b0);
		rde(4'h0, 32'h48);
		wr(4'h0, 32'h08);
		rde(4'h0, 32'h48);
		rde(4'he, 32'h0);
		rde(4'h5, {28'h0, cv[11:8]});
		rde(4'h0, 32'h08);
		rde(4'h6, {24'h0, cv[7:0]});
		wr(4'h0, 32'h28);
		pin(1'b0);
		check({31'h0, irq}, 32'h1);
		rde(4'h6, {24'h0, cv[7:0]});
		wr(4'he, 32'h1);
		@(posedge sys_clk);
		check({31'h0, irq}, 32'h0);
		$display("test main capture done");
		wr(4'h0, 32'h08);
		wr(4'h7, 32'h2);
		rnd = xs(rnd);
		auxv = rnd[7:0];
		aux_counter_value <= auxv;
		pin(1'b0);
		rde(4'h0, 32'h08);
		pin(1'b1);
		rde(4'h0, 32'h48);
		rde(4'h8, {24'h0, auxv});
		rde(4'h5, {28'h0, cv[11:8]});
		rde(4'h6, {24'h0, cv[7:0]});
		$display("test cascaded capture done");
		cv = cv + 12'h002;
		wr(4'h9, {20'h0, cv});
		rde(4'hd, 32'hf);
		wr(4'h0, 32'h09);
		ticks(2);
		repeat (3) @(posedge sys_clk);
		check({28'h0, compare_match}, 32'h1);
		check({31'h0, irq}, 32'h1);
		ticks(1);
		rde(4'hd, 32'h1);
		rde(4'hd, 32'h0);
		wr(4'he, 32'h4);
		@(posedge sys_clk);
		check({31'h0, irq}, 32'h0);
		$display("test compare done");
		cv = cv + 12'h001;
		wr(4'h0, 32'h18);
		ticks(5);
		rde(4'h2, {24'h0, cv[7:0]});
		wr(4'h0, 32'h00);
		ticks(5);
		rde(4'h2, {24'h0, cv[7:0]});
		wr(4'h0, 32'h10);
		wr(4'h0, 32'h00);
		rel = cv + 12'h004;
		cv = cv + 12'h001;
		rd(4'h2, {24'h0, cv[7:0]}, {24'h0, rel[7:0]});
		$display("test clock select done");
		end_sim();
	end
endmodule
`default_nettype wire
